// ---- verification/cbv_can_node.sv ----
// model: other can nodes sharing the wired-and bus line
`timescale 1ns/1ps
`default_nettype none
module cbv_can_node (
   input wire logic pclk,
   input wire logic bit_tick,
   input wire logic can_tx,
   input wire logic dom,
   output logic can_rx,
   output logic [28:0] seen
);
   // a dominant zero from any node wins the wire
   assign can_rx = can_tx & ~dom;
   // collect each sent bit at its bit tick, first bit ends up on top
   always @(posedge pclk) if (bit_tick) seen <= {seen[27:0], can_tx};
endmodule
`default_nettype wire

// ---- verification/cbv_rx_buffer_properties.sv ----
// checker: port-level properties of the receive buffer view
`timescale 1ns/1ps
`default_nettype none
module cbv_rx_buffer_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_frame_valid,
   input wire logic rx_remote_request_bit,
   input wire logic [3:0] rx_length_code,
   input wire logic tx_remote_request_bit,
   input wire logic [3:0] tx_length_code,
   input wire logic [3:0] tx_data_count,
   input wire logic rx_buffer_full
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus handshake and error response
   a_ready_ce: assert property (pready |-> ce) else $error("pready off");
   a_ready_nowait: assert property ((psel && !penable && ce) ##1 (penable && ce)
      |-> pready) else $error("wait state");
   a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray error");
   a_err_unal: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned taken");
   a_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper lanes set");
   a_len_resv: assert property (psel && penable && !pwrite && !pslverr &&
      paddr[7:2] == cbv_pkg::IDX_LENGTH |-> prdata[7:4] == 4'h0) else $error("length high bits");
   // a captured frame shows whole one cycle later
   a_full_frame: assert property (rx_frame_valid && ce |=> rx_buffer_full)
      else $error("full late");
   a_len_tx: assert property (rx_frame_valid && ce |=>
      tx_length_code == $past(rx_length_code)) else $error("length lost");
   a_rtr_tx: assert property (rx_frame_valid && ce |=>
      tx_remote_request_bit == $past(rx_remote_request_bit)) else $error("remote flag lost");
   // outgoing byte count follows stored flag and code
   a_remote_zero: assert property ($past(ce) && $past(tx_remote_request_bit) |->
      tx_data_count == 4'h0) else $error("remote frame data");
   a_count_code: assert property ($past(ce) && !$past(tx_remote_request_bit) |->
      tx_data_count == (($past(tx_length_code) > 4'h8) ? 4'h8 : $past(tx_length_code)))
      else $error("byte count");
   c_frame: cover property (rx_frame_valid && ce);
   c_remote: cover property (rx_frame_valid && rx_remote_request_bit);
   c_big_code: cover property (rx_frame_valid && rx_length_code > 4'h8);
   c_error: cover property (pslverr);
   c_wait: cover property (psel && penable && !pready);
endmodule
bind cbv_rx_buffer cbv_rx_buffer_properties chk_u (.pclk, .presetn, .ce, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .rx_frame_valid, .rx_remote_request_bit,
   .rx_length_code, .tx_remote_request_bit, .tx_length_code, .tx_data_count, .rx_buffer_full);
`default_nettype wire

// ---- verification/cbv_rx_buffer_tb_top.sv ----
// testbench: frames, time stamps and arbitration of the receive buffer view
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module cbv_rx_buffer_tb_top;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, bit_tick = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, seed;
   logic pready, pslverr, can_rx, can_tx, tx_remote_request_bit, rx_buffer_full, dom = 0;
   logic rx_frame_valid = 0, rx_remote_request_bit = 0;
   logic rx_substitute_remote_flag = 1, rx_extended_id_flag = 1;
   logic [28:0] rx_extended_identifier = '0, seen, id;
   logic [3:0] rx_length_code = '0, tx_length_code, tx_data_count, l;
   logic [63:0] rx_data_bits = '0, d;
   logic [32:0] exp_q[$], e;
   int num_errors = 0, n_checks = 0, k;
   cbv_rx_buffer dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .rx_frame_valid, .rx_extended_identifier,
      .rx_substitute_remote_flag, .rx_extended_id_flag, .rx_remote_request_bit,
      .rx_length_code, .rx_data_bits, .bit_tick, .can_rx, .can_tx, .tx_remote_request_bit,
      .tx_length_code, .tx_data_count, .rx_buffer_full);
   cbv_can_node node_u (.pclk, .bit_tick, .can_tx, .dom, .can_rx, .seen);
   always #4 pclk = ~pclk;
   function automatic logic [7:0] ba(input logic [5:0] i);
      return {i, 2'h0};
   endfunction
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      exp_q.push_back(x);
      apb(a, 0, 8'h0);
   endtask
   task automatic tick();
      @(posedge pclk);
      bit_tick <= 1;
      @(posedge pclk);
      bit_tick <= 0;
      repeat (6) @(posedge pclk);
   endtask
   task automatic frame(input logic r);
      @(posedge pclk);
      rx_frame_valid <= 1;
      rx_extended_identifier <= id;
      rx_remote_request_bit <= r;
      rx_length_code <= l;
      rx_data_bits <= d;
      @(posedge pclk);
      rx_frame_valid <= 0;
   endtask
   // read back identifier bytes, remote flag, data bytes up to the length code but at most eight, and the length code of the last frame
   task automatic chk_buf(input logic r);
      int i;
      rd(ba(cbv_pkg::IDX_EXT_ID2), {25'h0, id[14:7]});
      rd(ba(cbv_pkg::IDX_EXT_ID3), {25'h0, id[6:0], r});
      for (i = 0; i < 8 && i < l; i++) begin
         rd(ba(cbv_pkg::IDX_DATA0 + 6'(i)), {25'h0, d[8*i+:8]});
      end
      rd(ba(cbv_pkg::IDX_LENGTH), {29'h0, l});
   endtask
   task automatic end_of_test();
      if (exp_q.size() != 0) num_errors++;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // compare each completed read with the oldest expected word
   always @(negedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = exp_q.pop_front();
         `CHK({pslverr, prdata}, e)
      end
   end
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end
   initial begin
      seed = $urandom(32'h8a517e05);
      repeat (8) @(posedge pclk);
      presetn <= 1;
      rd(8'hc0, {1'b1, 32'h0});
      rd(8'h89, {1'b1, 32'h0});
      for (k = 0; k < 4; k++) begin
         id = 29'($urandom) | 29'h10000000;
         d = {$urandom, $urandom};
         l = (k == 0) ? 4'h0 : (k == 1) ? 4'h8 : (k == 2) ? 4'($urandom_range(7, 1)) : 4'hf;
         frame(k[0]);
         chk_buf(k[0]);
      end
      // clock enable low: the frame is ignored and a read waits for its data
      ce <= 0;
      frame(0);
      fork
         rd(ba(cbv_pkg::IDX_EXT_ID3), {25'h0, id[6:0], 1'b1});
         begin
            repeat (3) @(posedge pclk);
            ce <= 1;
         end
      join
      // stamping with init mode off, then a write that must not stick
      apb(ba(cbv_pkg::IDX_CTRL), 1, 8'h01);
      repeat (5) tick();
      frame(0);
      rd(ba(cbv_pkg::IDX_TS_HIGH), {25'h0, 8'h05});
      apb(ba(cbv_pkg::IDX_TS_HIGH), 1, 8'haa);
      rd(ba(cbv_pkg::IDX_TS_HIGH), {25'h0, 8'h05});
      apb(ba(cbv_pkg::IDX_CTRL), 1, 8'h03);
      repeat (3) tick();
      frame(0);
      rd(ba(cbv_pkg::IDX_TS_HIGH), 33'h0);
      // clean arbitration, then one lost to a dominant node
      for (k = 0; k < 2; k++) begin
         dom <= k[0];
         apb(ba(cbv_pkg::IDX_CTRL), 1, 8'h04);
         repeat (3) @(posedge pclk);
         repeat (29) tick();
         if (k == 0) `CHK(seen, id)
         rd(ba(cbv_pkg::IDX_STATUS), {31'h0, k[0], 1'b1});
      end
      dom <= 0;
      repeat (4) @(posedge pclk);
      end_of_test();
   end
endmodule
`undef CHK
`default_nettype wire

// ---- verilog/cbv_arb_if.sv ----
// interface: buffer core to identifier arbitration shifter
`timescale 1ns/1ps
`default_nettype none
interface cbv_arb_if;
   logic load;
   logic tick;
   logic [cbv_pkg::ID_W-1:0] id;
   logic bus_bit;
   logic tx_bit;
   logic busy;
   logic lost;
   logic done;
   modport ctrl(output load, tick, id, bus_bit, input tx_bit, busy, lost, done);
   modport shifter(input load, tick, id, bus_bit, output tx_bit, busy, lost, done);
endinterface
`default_nettype wire

// ---- verilog/cbv_id_shifter.sv ----
// module: sends the extended identifier msb first and watches arbitration
`timescale 1ns/1ps
`default_nettype none
module cbv_id_shifter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   cbv_arb_if.shifter arb
);
   typedef struct packed {
      cbv_pkg::cbv_arb_state_t state;
      logic [cbv_pkg::ID_W-1:0] shreg;
      logic [4:0] cnt;
      logic tx_bit;
      logic lost;
      logic done;
   } cbv_shift_t;

   localparam cbv_shift_t SH_RESET = '{state: cbv_pkg::ARB_IDLE, tx_bit: 1'b1, default: '0};

   cbv_shift_t q;
   cbv_shift_t next_q;

   // one bit per bit tick; a recessive bit read back dominant loses
   always_comb begin
      next_q = q;
      next_q.lost = 1'b0;
      next_q.done = 1'b0;
      case (q.state)
         cbv_pkg::ARB_IDLE: begin
            next_q.tx_bit = 1'b1;
            if (arb.load) begin
               next_q.shreg = arb.id;
               next_q.tx_bit = arb.id[cbv_pkg::ID_MSB];
               next_q.cnt = cbv_pkg::ID_LAST;
               next_q.state = cbv_pkg::ARB_SHIFT;
            end
         end
         cbv_pkg::ARB_SHIFT: begin
            if (arb.tick) begin
               if (q.tx_bit && !arb.bus_bit) begin
                  next_q.lost = 1'b1;
                  next_q.tx_bit = 1'b1;
                  next_q.state = cbv_pkg::ARB_IDLE;
               end else if (q.cnt == 5'h00) begin
                  next_q.done = 1'b1;
                  next_q.tx_bit = 1'b1;
                  next_q.state = cbv_pkg::ARB_IDLE;
               end else begin
                  next_q.shreg = {q.shreg[cbv_pkg::ID_W-2:0], 1'b1};
                  next_q.tx_bit = q.shreg[cbv_pkg::ID_MSB-1];
                  next_q.cnt = q.cnt - 5'h01;
               end
            end
         end
         default: next_q = SH_RESET;
      endcase
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= SH_RESET;
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign arb.tx_bit = q.tx_bit;
   assign arb.busy = (q.state == cbv_pkg::ARB_SHIFT);
   assign arb.lost = q.lost;
   assign arb.done = q.done;
endmodule
`default_nettype wire

// ---- verilog/cbv_pkg.sv ----
// package: register map, field layout and constants of the can receive buffer view
package cbv_pkg;
   localparam int ID_W = 29;
   localparam int ID_MSB = 28;
   localparam logic [4:0] ID_LAST = 5'h1c;
   localparam int TS_W = 16;
   localparam int TS_HI_LSB = 0;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_EXT_ID2 = 6'h22;
   localparam logic [5:0] IDX_EXT_ID3 = 6'h23;
   localparam logic [5:0] IDX_DATA0 = 6'h24;
   localparam logic [5:0] IDX_DATA7 = 6'h2b;
   localparam logic [5:0] IDX_LENGTH = 6'h2c;
   localparam logic [5:0] IDX_TS_HIGH = 6'h2e;
   localparam logic [5:0] IDX_CTRL = 6'h38;
   localparam logic [5:0] IDX_STATUS = 6'h39;
   // control register bits
   localparam int CTRL_TIME_EN = 0;
   localparam int CTRL_INIT = 1;
   localparam int CTRL_TX_GO = 2;
   // status register bits
   localparam int STAT_FULL = 0;
   localparam int STAT_LOST = 1;
   localparam int STAT_BUSY = 2;
   // values after reset, and the largest data byte count
   localparam logic INIT_RESET = 1'b1;
   localparam logic TIME_EN_RESET = 1'b0;
   localparam logic [7:0] BUF_RESET = 8'h00;
   localparam logic [3:0] DLC_MAX = 4'h8;
   typedef enum logic [0:0] {
      ARB_IDLE = 1'b0,
      ARB_SHIFT = 1'b1
   } cbv_arb_state_t;
endpackage

// ---- verilog/cbv_rx_buffer.sv ----
// module: can receive buffer view with apb register access and time stamp
`timescale 1ns/1ps
`default_nettype none
module cbv_rx_buffer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_frame_valid,
   input wire logic [28:0] rx_extended_identifier,
   input wire logic rx_substitute_remote_flag,
   input wire logic rx_extended_id_flag,
   input wire logic rx_remote_request_bit,
   input wire logic [3:0] rx_length_code,
   input wire logic [63:0] rx_data_bits,
   input wire logic bit_tick,
   input wire logic can_rx,
   output logic can_tx,
   output logic tx_remote_request_bit,
   output logic [3:0] tx_length_code,
   output logic [3:0] tx_data_count,
   output logic rx_buffer_full
);
   typedef struct packed {
      logic [13:0] id_hi;
      logic [7:0] ext_id_mid_bits;
      logic [6:0] ext_id_low_bits;
      logic remote_request_flag;
      logic substitute_remote_flag;
      logic extended_id_flag;
      logic [7:0][7:0] data;
      logic [3:0] length_code;
      logic [cbv_pkg::TS_W-1:0] timer;
      logic [7:0] ts_high;
      logic time_en;
      logic init_mode;
      logic full;
      logic lost;
      logic go;
      logic [3:0] tx_count;
      logic rx_meta;
      logic rx_sync;
      logic [31:0] rdata;
      logic rd_ok;
   } cbv_state_t;

   // buffer contents are undefined for software; zero is just what we load
   localparam cbv_state_t ST_RESET = '{
      init_mode: cbv_pkg::INIT_RESET,
      time_en: cbv_pkg::TIME_EN_RESET,
      default: '0
   };

   cbv_state_t q;
   cbv_state_t next_q;
   cbv_arb_if arb ();

   logic [5:0] idx;
   logic aligned;
   logic setup;
   logic access;
   logic wr;
   logic hit;
   logic [7:0] rd_byte;
   logic [2:0] dsel;
   logic [7:0] wbyte;

   assign idx = paddr[7:2];
   assign aligned = (paddr[1:0] == 2'h0);
   // a transfer captures read data every cycle until its completing access cycle
   assign setup = psel && !access;
   assign access = psel && penable && pready;
   assign dsel = 3'(idx - cbv_pkg::IDX_DATA0);
   assign wbyte = pwdata[7:0];

   // address decode and read mux; unmapped words read zero with an error
   always_comb begin
      hit = aligned;
      rd_byte = 8'h00;
      if (!aligned) begin
         hit = 1'b0;
      end else if (idx == cbv_pkg::IDX_EXT_ID2) begin
         rd_byte = q.ext_id_mid_bits;
      end else if (idx == cbv_pkg::IDX_EXT_ID3) begin
         rd_byte = {q.ext_id_low_bits, q.remote_request_flag};
      end else if (idx >= cbv_pkg::IDX_DATA0 && idx <= cbv_pkg::IDX_DATA7) begin
         rd_byte = q.data[dsel];
      end else if (idx == cbv_pkg::IDX_LENGTH) begin
         rd_byte = {4'h0, q.length_code};
      end else if (idx == cbv_pkg::IDX_TS_HIGH) begin
         rd_byte = q.ts_high;
      end else if (idx == cbv_pkg::IDX_CTRL) begin
         rd_byte = {5'h00, 1'b0, q.init_mode, q.time_en};
      end else if (idx == cbv_pkg::IDX_STATUS) begin
         rd_byte = {5'h00, arb.busy, q.lost, q.full};
      end else begin
         hit = 1'b0;
      end
   end

   assign wr = access && pwrite && hit;

   // next state: synchroniser, timer, register writes, frame capture
   always_comb begin
      next_q = q;
      next_q.go = 1'b0;
      // can_rx pin passes two flops before anything reads it
      next_q.rx_meta = can_rx;
      next_q.rx_sync = q.rx_meta;
      // free-running stamp timer, wraps silently, zero in init mode
      if (q.init_mode) begin
         next_q.timer = '0;
      end else if (bit_tick) begin
         next_q.timer = q.timer + 16'h0001;
      end
      // read data is taken before completion and held to the access
      next_q.rd_ok = setup;
      if (setup) begin
         next_q.rdata = {24'h000000, rd_byte};
      end
      // software writes; time stamp word ignores them
      if (wr) begin
         if (idx == cbv_pkg::IDX_EXT_ID2) begin
            next_q.ext_id_mid_bits = wbyte;
         end else if (idx == cbv_pkg::IDX_EXT_ID3) begin
            next_q.ext_id_low_bits = wbyte[7:1];
            next_q.remote_request_flag = wbyte[0];
         end else if (idx >= cbv_pkg::IDX_DATA0 && idx <= cbv_pkg::IDX_DATA7) begin
            next_q.data[dsel] = wbyte;
         end else if (idx == cbv_pkg::IDX_LENGTH) begin
            next_q.length_code = wbyte[3:0];
         end else if (idx == cbv_pkg::IDX_TS_HIGH) begin
            next_q.ts_high = q.ts_high;
         end else if (idx == cbv_pkg::IDX_CTRL) begin
            next_q.time_en = wbyte[cbv_pkg::CTRL_TIME_EN];
            next_q.init_mode = wbyte[cbv_pkg::CTRL_INIT];
            next_q.go = wbyte[cbv_pkg::CTRL_TX_GO] && !arb.busy;
         end else if (idx == cbv_pkg::IDX_STATUS) begin
            // write one to clear
            if (wbyte[cbv_pkg::STAT_FULL]) begin
               next_q.full = 1'b0;
            end
            if (wbyte[cbv_pkg::STAT_LOST]) begin
               next_q.lost = 1'b0;
            end
         end
      end
      // lost arbitration is sticky; the set beats a clear
      if (arb.lost) begin
         next_q.lost = 1'b1;
      end
      // a valid frame overwrites the buffer in one cycle and then shows full
      if (rx_frame_valid) begin
         next_q.id_hi = rx_extended_identifier[28:15];
         next_q.ext_id_mid_bits = rx_extended_identifier[14:7];
         next_q.ext_id_low_bits = rx_extended_identifier[6:0];
         next_q.remote_request_flag = rx_remote_request_bit;
         next_q.substitute_remote_flag = rx_substitute_remote_flag;
         next_q.extended_id_flag = rx_extended_id_flag;
         next_q.length_code = rx_length_code;
         for (int i = 0; i < 8; i++) begin
            // bytes past the length code are stored but meaningless
            next_q.data[i] = rx_data_bits[i*8 +: 8];
         end
         if (q.time_en) begin
            next_q.ts_high = q.timer[cbv_pkg::TS_HI_LSB +: 8];
         end
         next_q.full = 1'b1;
      end
      // byte count for sending; remote frames carry no data
      if (q.remote_request_flag) begin
         next_q.tx_count = 4'h0;
      end else if (q.length_code > cbv_pkg::DLC_MAX) begin
         next_q.tx_count = cbv_pkg::DLC_MAX;
      end else begin
         next_q.tx_count = q.length_code;
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= ST_RESET;
      end else if (ce) begin
         q <= next_q;
      end
   end

   // identifier for arbitration, msb first
   assign arb.load = q.go;
   assign arb.tick = bit_tick;
   assign arb.id = {q.id_hi, q.ext_id_mid_bits, q.ext_id_low_bits};
   assign arb.bus_bit = q.rx_sync;

   cbv_id_shifter u_shifter (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .arb(arb)
   );

   // bus answer: zero wait states while ce is high; any transfer waits while ce is low,
   // and a read whose setup saw ce low waits until a cycle with ce high has captured its data
   assign pready = ce && (pwrite || q.rd_ok);
   assign pslverr = psel && penable && !hit;
   assign prdata = q.rdata;
   assign can_tx = arb.tx_bit;
   assign tx_remote_request_bit = q.remote_request_flag;
   assign tx_length_code = q.length_code;
   assign tx_data_count = q.tx_count;
   assign rx_buffer_full = q.full;
endmodule
`default_nettype wire
